// ===== adc_ctrl_pkg.sv
// Purpose: Shared constants and types for the converter mode and calibration control.
// Assumes: 24-bit control word, MSB first on the serial port.
// Notes: Reset values that nothing fixes are plain defaults.
package adc_ctrl_pkg;

    localparam int WORD_W = 24;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] WORD_BITS = 5'h18;
    localparam logic [CNT_W-1:0] LAST_BIT = 5'h17;

    // Control word field layout
    localparam int MODE_HI = 23;
    localparam int MODE_LO = 21;
    localparam int GAIN_HI = 20;
    localparam int GAIN_LO = 18;
    localparam int CHAN_HI = 17;
    localparam int CHAN_LO = 16;
    localparam int WL_BIT = 15;
    localparam int RO_BIT = 14;
    localparam int BO_BIT = 13;
    localparam int BU_BIT = 12;
    localparam int FILT_HI = 11;
    localparam int FILT_LO = 0;

    // Operating-mode codes
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_SELF_CAL = 3'h1;
    localparam logic [2:0] MODE_SYS_ZERO = 3'h2;
    localparam logic [2:0] MODE_SYS_FULL = 3'h3;
    localparam logic [2:0] MODE_SYS_OFFSET = 3'h4;
    localparam logic [2:0] MODE_BACKGROUND = 3'h5;
    localparam logic [2:0] MODE_ZS_ACCESS = 3'h6;
    localparam logic [2:0] MODE_FS_ACCESS = 3'h7;

    localparam logic [1:0] CHAN_FIRST = 2'h0;
    localparam logic [1:0] CHAN_SECOND = 2'h1;
    localparam logic [1:0] CHAN_HIGH = 2'h2;

    localparam logic [2:0] GAIN_RST = 3'h0;
    localparam logic [11:0] FILTER_CODE_RST = 12'h000;
    localparam logic [WORD_W-1:0] CTRL_RST = {MODE_NORMAL, GAIN_RST, CHAN_FIRST,
                                              4'h0, FILTER_CODE_RST};
    localparam logic [WORD_W-1:0] COEF_ZS_RST = 24'h000000;
    localparam logic [WORD_W-1:0] COEF_FS_RST = 24'h800000;
    // Low byte dropped when results are 16 bits wide
    localparam logic [WORD_W-1:0] SHORT_RESULT_MASK = 24'hFFFF00;

    // Background sequence: one published result per six conversions
    localparam logic [2:0] BG_LAST_SLOT = 3'h5;
    localparam logic [2:0] BG_PUB_SLOT = 3'h0;

    typedef enum logic [1:0] {MEAS_INPUT, MEAS_SHORTED, MEAS_REF} meas_type;

    function automatic logic [7:0] gain_decode(input logic [2:0] code);
        gain_decode = 8'h01 << code;
    endfunction

    function automatic meas_type bg_target(input logic [2:0] slot);
        meas_type t;
        t = MEAS_INPUT;
        if (slot == 3'h1 || slot == 3'h4) begin
            t = MEAS_SHORTED;
        end else if (slot == 3'h2 || slot == 3'h5) begin
            t = MEAS_REF;
        end
        bg_target = t;
    endfunction

endpackage

// ===== bit_sync.sv
// Purpose: Two-flop synchroniser for independent levels.
// Assumes: Each bit is a level that holds for several destination clocks.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ps
module bit_sync #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [W-1:0] din,
    input wire logic [W-1:0] rst_val,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // Reset takes the all-ones constant; the rst_val input is not used
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= '1;
            sync_r <= '1;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
        end
    end

    assign dout = sync_r;
endmodule

// ===== cal_step_unit.sv
// Purpose: Sequences calibration steps and the background slot pattern.
// Assumes: conv_valid marks one finished measurement of the requested target.
// Notes: Coefficient values come from the front end; this only decides where they go.
`timescale 1ns/1ps
module cal_step_unit
    import adc_ctrl_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [2:0] mode,
    input wire logic conv_valid,
    output logic zs_wr,
    output logic fs_wr,
    output logic data_pub,
    output logic done,
    output logic busy,
    output meas_type target
);
    typedef enum logic [1:0] {ST_IDLE, ST_ZERO, ST_FULL, ST_BACK} cal_state_type;
    cal_state_type state_r;
    logic [2:0] slot_r;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
        end else if (start) begin
            unique case (mode)
                MODE_SELF_CAL, MODE_SYS_ZERO, MODE_SYS_OFFSET: state_r <= ST_ZERO;
                MODE_SYS_FULL: state_r <= ST_FULL;
                MODE_BACKGROUND: state_r <= ST_BACK;
                default: state_r <= ST_IDLE;
            endcase
        end else if (conv_valid) begin
            unique case (state_r)
                ST_ZERO: state_r <= (mode == MODE_SYS_ZERO) ? ST_IDLE : ST_FULL;
                ST_FULL: state_r <= ST_IDLE;
                ST_IDLE, ST_BACK: state_r <= state_r;
            endcase
        end
    end

    // Slot counter restarts with every new command
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            slot_r <= 3'h0;
        end else if (start || state_r != ST_BACK) begin
            slot_r <= 3'h0;
        end else if (conv_valid) begin
            slot_r <= (slot_r == BG_LAST_SLOT) ? 3'h0 : slot_r + 3'h1;
        end
    end

    always_comb begin
        zs_wr = 1'b0;
        fs_wr = 1'b0;
        data_pub = 1'b0;
        done = 1'b0;
        target = MEAS_INPUT;
        unique case (state_r)
            ST_IDLE: data_pub = conv_valid;
            ST_ZERO: begin
                target = (mode == MODE_SELF_CAL) ? MEAS_SHORTED : MEAS_INPUT;
                zs_wr = conv_valid;
                done = conv_valid && mode == MODE_SYS_ZERO;
            end
            ST_FULL: begin
                target = (mode == MODE_SYS_FULL) ? MEAS_INPUT : MEAS_REF;
                fs_wr = conv_valid;
                done = conv_valid;
            end
            ST_BACK: begin
                target = bg_target(slot_r);
                zs_wr = conv_valid && target == MEAS_SHORTED;
                fs_wr = conv_valid && target == MEAS_REF;
                data_pub = conv_valid && slot_r == BG_PUB_SLOT;
            end
        endcase
    end

    assign busy = (state_r == ST_ZERO) || (state_r == ST_FULL);
endmodule

// ===== adc_mode_calibration_control.sv
// Purpose: Control word, calibration coefficients and serial port of the converter.
// Assumes: sclk runs only inside frames; master samples sdata_out on falling sclk.
// Notes: Analog front end and filter are outside; they report via conv_valid.
`timescale 1ns/1ps
module adc_mode_calibration_control
    import adc_ctrl_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic transmit_frame_n,
    input wire logic read_frame_n,
    input wire logic reg_select,
    input wire logic sdata_in,
    output logic sdata_out,
    output logic sdata_oe_n,
    output logic result_ready_n,
    input wire logic conv_valid,
    input wire logic [WORD_W-1:0] conv_code,
    output meas_type meas_target,
    output logic [7:0] pga_gain,
    output logic diff_input_first,
    output logic diff_input_second,
    output logic high_level_input,
    output logic result_width_sel,
    output logic excitation_current_en,
    output logic burnout_current_en,
    output logic unipolar_en,
    output logic [11:0] filter_code,
    output logic cal_busy
);

    // ---------------- Link domain (sclk) ----------------

    logic wr_arst_n;
    logic rd_arst_n;
    logic [CNT_W-1:0] wr_cnt_r;
    logic [WORD_W-1:0] wr_shift_r;
    logic [WORD_W-1:0] wr_word_r;
    logic wr_sel_r;
    logic wr_tog_r;
    logic [CNT_W-1:0] rd_cnt_r;
    logic [WORD_W-1:0] rd_shift_r;

    // Counters are cleared while their frame is idle, because sclk
    // gives no edge between frames to clear them on.
    assign wr_arst_n = rst_b & ~transmit_frame_n;
    assign rd_arst_n = rst_b & ~read_frame_n;

    // Saturating count ignores extra clocks
    always_ff @(posedge sclk or negedge wr_arst_n) begin
        if (!wr_arst_n) begin
            wr_cnt_r <= '0;
            wr_shift_r <= '0;
        end else if (wr_cnt_r != WORD_BITS) begin
            wr_cnt_r <= wr_cnt_r + 5'h01;
            wr_shift_r <= {wr_shift_r[WORD_W-2:0], sdata_in};
        end
    end

    // A word is handed over only on the 24th bit; short frames never
    // reach it and clocks after it find the counter saturated.
    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            wr_word_r <= '0;
            wr_sel_r <= 1'b0;
            wr_tog_r <= 1'b0;
        end else if (!transmit_frame_n && wr_cnt_r == LAST_BIT) begin
            wr_word_r <= {wr_shift_r[WORD_W-2:0], sdata_in};
            wr_sel_r <= reg_select;
            wr_tog_r <= ~wr_tog_r;
        end
    end

    logic [WORD_W-1:0] tx_word_r;

    // First edge loads the frozen core word; bits then leave MSB first.
    always_ff @(posedge sclk or negedge rd_arst_n) begin
        if (!rd_arst_n) begin
            rd_cnt_r <= '0;
            rd_shift_r <= '0;
        end else if (rd_cnt_r == '0) begin
            rd_cnt_r <= 5'h01;
            rd_shift_r <= tx_word_r;
        end else if (rd_cnt_r != WORD_BITS) begin
            rd_cnt_r <= rd_cnt_r + 5'h01;
            rd_shift_r <= {rd_shift_r[WORD_W-2:0], 1'b0};
        end else begin
            // Zeros after the 24th bit
            rd_shift_r <= '0;
        end
    end

    assign sdata_out = rd_shift_r[WORD_W-1];
    assign sdata_oe_n = read_frame_n;

    // ---------------- Core domain (clock) ----------------

    logic [2:0] sync_in;
    logic [2:0] sync_out;
    logic wr_tog_s;
    logic rd_frame_n_s;
    logic sel_s;
    logic wr_tog_d_r;
    logic rd_frame_n_d_r;
    logic wr_evt;
    logic rd_end;

    // Pins reach core logic only via two flops
    assign sync_in = {wr_tog_r, read_frame_n, reg_select};

    bit_sync #(.W(3)) u_sync (
        .clock(clock),
        .rst_b(rst_b),
        .din(sync_in),
        .rst_val(3'h7),
        .dout(sync_out)
    );

    assign wr_tog_s = sync_out[2];
    assign rd_frame_n_s = sync_out[1];
    assign sel_s = sync_out[0];

    // Reset of the sync chain is all ones, so the edge store matches it
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_tog_d_r <= 1'b1;
            rd_frame_n_d_r <= 1'b1;
        end else begin
            wr_tog_d_r <= wr_tog_s;
            rd_frame_n_d_r <= rd_frame_n_s;
        end
    end

    logic tog_armed_r;

    // The toggle flop resets low but the chain resets high; ignore the
    // first difference that reset alone creates.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tog_armed_r <= 1'b0;
        end else if (!tog_armed_r && wr_tog_s == wr_tog_d_r && !wr_tog_s) begin
            tog_armed_r <= 1'b1;
        end
    end

    // Frames outlast the sync delay, so toggles never merge
    assign wr_evt = tog_armed_r && (wr_tog_s ^ wr_tog_d_r);
    assign rd_end = rd_frame_n_s && !rd_frame_n_d_r;

    logic [WORD_W-1:0] ctrl_r;
    logic [2:0] mode;
    logic [1:0] chan;
    logic ctrl_write;
    logic coef_write;
    logic cal_start_r;
    logic zs_wr;
    logic fs_wr;
    logic data_pub;
    logic cal_done;

    assign mode = ctrl_r[MODE_HI:MODE_LO];
    assign chan = ctrl_r[CHAN_HI:CHAN_LO];
    assign ctrl_write = wr_evt && !wr_sel_r;
    assign coef_write = wr_evt && wr_sel_r;

    // Shared by the write path and the read source
    function automatic logic zs_access(input logic [2:0] m);
        zs_access = m == MODE_ZS_ACCESS;
    endfunction

    function automatic logic fs_access(input logic [2:0] m);
        fs_access = m == MODE_FS_ACCESS;
    endfunction

    // Host write wins over the automatic return to normal mode;
    // a write during a calibration abandons it
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= CTRL_RST;
        end else if (ctrl_write) begin
            ctrl_r <= wr_word_r;
        end else if (cal_done) begin
            ctrl_r[MODE_HI:MODE_LO] <= MODE_NORMAL;
        end
    end

    // Mode decode sees the new word one cycle after it lands
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cal_start_r <= 1'b0;
        end else begin
            cal_start_r <= ctrl_write;
        end
    end

    cal_step_unit u_cal (
        .clock(clock),
        .rst_b(rst_b),
        .start(cal_start_r),
        .mode(mode),
        .conv_valid(conv_valid),
        .zs_wr(zs_wr),
        .fs_wr(fs_wr),
        .data_pub(data_pub),
        .done(cal_done),
        .busy(cal_busy),
        .target(meas_target)
    );

    // One coefficient pair per channel code; code 11 has storage but no input.
    // A host write beats a background update in the same cycle;
    // the next background pass rewrites it anyway.
    logic [WORD_W-1:0] zs_coef_r [4];
    logic [WORD_W-1:0] fs_coef_r [4];

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 4; i++) begin
                zs_coef_r[i] <= COEF_ZS_RST;
            end
        end else if (coef_write && zs_access(mode)) begin
            zs_coef_r[chan] <= wr_word_r;
        end else if (zs_wr) begin
            zs_coef_r[chan] <= conv_code;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 4; i++) begin
                fs_coef_r[i] <= COEF_FS_RST;
            end
        end else if (coef_write && fs_access(mode)) begin
            fs_coef_r[chan] <= wr_word_r;
        end else if (fs_wr) begin
            fs_coef_r[chan] <= conv_code;
        end
    end

    // 16-bit results keep the top two bytes, low byte zero
    logic [WORD_W-1:0] data_r;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            data_r <= '0;
        end else if (data_pub) begin
            data_r <= ctrl_r[WL_BIT] ? conv_code : (conv_code & SHORT_RESULT_MASK);
        end
    end

    // Ready falls on a new result or a finished calibration and rises
    // once a result read ends or a control word is written; a new event in that cycle keeps it low.
    logic result_read_end;

    assign result_read_end = rd_end && sel_s &&
                             (mode == MODE_NORMAL || mode == MODE_BACKGROUND);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            result_ready_n <= 1'b1;
        end else if (data_pub || cal_done) begin
            result_ready_n <= 1'b0;
        end else if (result_read_end || cal_start_r) begin
            result_ready_n <= 1'b1;
        end
    end

    // Read source; frozen for the whole read frame so the link side
    // may load it on its first edge without a handshake.
    // It freezes two or three clocks after the frame falls, so the
    // first read clock must come later than that.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tx_word_r <= '0;
        end else if (rd_frame_n_s) begin
            if (!sel_s) begin
                tx_word_r <= ctrl_r;
            end else if (zs_access(mode)) begin
                tx_word_r <= zs_coef_r[chan];
            end else if (fs_access(mode)) begin
                tx_word_r <= fs_coef_r[chan];
            end else begin
                tx_word_r <= data_r;
            end
        end
    end

    // Front-end settings, registered from the control word
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pga_gain <= gain_decode(GAIN_RST);
            result_width_sel <= 1'b0;
            filter_code <= FILTER_CODE_RST;
        end else begin
            pga_gain <= gain_decode(ctrl_r[GAIN_HI:GAIN_LO]);
            result_width_sel <= ctrl_r[WL_BIT];
            filter_code <= ctrl_r[FILT_HI:FILT_LO];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            excitation_current_en <= 1'b0;
            burnout_current_en <= 1'b0;
            unipolar_en <= 1'b0;
        end else begin
            excitation_current_en <= ctrl_r[RO_BIT];
            burnout_current_en <= ctrl_r[BO_BIT];
            unipolar_en <= ctrl_r[BU_BIT];
        end
    end

    // Code 11 selects no input at all
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            diff_input_first <= 1'b1;
            diff_input_second <= 1'b0;
            high_level_input <= 1'b0;
        end else begin
            diff_input_first <= chan == CHAN_FIRST;
            diff_input_second <= chan == CHAN_SECOND;
            high_level_input <= chan == CHAN_HIGH;
        end
    end

endmodule

// ===== adc_mode_calibration_control_assertions.sv
// Purpose: Port-level checks for the mode and calibration control.
// Assumes: Everything watched here is sampled on the core clock.
// Notes: Settings may only move while or just after a write frame.
`timescale 1ns/1ps
module adc_mode_calibration_control_checker
    import adc_ctrl_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic transmit_frame_n,
    input wire logic read_frame_n,
    input wire logic sdata_oe_n,
    input wire logic result_ready_n,
    input wire logic conv_valid,
    input meas_type meas_target,
    input wire logic [7:0] pga_gain,
    input wire logic diff_input_first,
    input wire logic diff_input_second,
    input wire logic high_level_input,
    input wire logic result_width_sel,
    input wire logic excitation_current_en,
    input wire logic burnout_current_en,
    input wire logic unipolar_en,
    input wire logic [11:0] filter_code,
    input wire logic cal_busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    logic [3:0] idle_cnt_r;
    logic [26:0] settings;
    assign settings = {pga_gain, diff_input_first, diff_input_second, high_level_input, result_width_sel,
                       excitation_current_en, burnout_current_en, unipolar_en, filter_code};

    // Saturates so a long idle spell never wraps back into the allowed window
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            idle_cnt_r <= 4'h0;
        end else if (!transmit_frame_n) begin
            idle_cnt_r <= 4'h0;
        end else if (idle_cnt_r != 4'hF) begin
            idle_cnt_r <= idle_cnt_r + 4'h1;
        end
    end

    property p_gain_pow2;
        $onehot(pga_gain);
    endproperty
    a_gain_pow2: assert property (p_gain_pow2) else $error("gain output not a power of two");

    property p_chan_one;
        $onehot0({diff_input_first, diff_input_second, high_level_input});
    endproperty
    a_chan_one: assert property (p_chan_one) else $error("more than one input selected");

    property p_oe_follows;
        sdata_oe_n == read_frame_n;
    endproperty
    a_oe_follows: assert property (p_oe_follows) else $error("data drive outside read frame");

    property p_ready_cause;
        $fell(result_ready_n) |-> $past(conv_valid) || $past(conv_valid, 2);
    endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("ready without a finished measurement");

    property p_busy_start;
        $rose(cal_busy) |-> meas_target != MEAS_REF;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("calibration started on reference");

    property p_busy_end;
        $fell(cal_busy) |-> $past(conv_valid);
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("calibration ended without measurement");

    property p_busy_ready;
        $fell(cal_busy) |-> ##[0:1] !result_ready_n;
    endproperty
    a_busy_ready: assert property (p_busy_ready) else $error("no ready after calibration");

    property p_settings_frame;
        !$stable(settings) |-> idle_cnt_r < 4'h8;
    endproperty
    a_settings_frame: assert property (p_settings_frame) else $error("settings moved without a write");
endmodule

// ===== serial_host_model.sv
// Purpose: Microcontroller side of the serial port.
// Assumes: Link clock runs only inside frames, 160 ns period.
// Notes: Released data line toggles so a stale bit is never mistaken for data.
`timescale 1ns/1ps
module serial_host_model (
    output logic sclk,
    output logic transmit_frame_n,
    output logic read_frame_n,
    output logic reg_select,
    output logic sdata_in,
    input wire logic sdata_out,
    input wire logic sdata_oe_n
);
    logic host_d;
    assign sdata_in = sdata_oe_n ? host_d : sdata_out;

    initial begin
        sclk = 1'b0;
        transmit_frame_n = 1'b1;
        read_frame_n = 1'b1;
        reg_select = 1'b0;
        host_d = 1'b0;
    end

    task automatic write_word(input logic s, input logic [23:0] d, input int n);
        int k;
        reg_select = s;
        #200 transmit_frame_n = 1'b0;
        for (k = 0; k < n; k++) begin
            host_d = (k < 24) ? d[23-k] : 1'($urandom);
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
        end
        #80 transmit_frame_n = 1'b1;
        host_d = ~host_d;
        #1000;
    endtask

    task automatic read_word(input logic s, output logic [23:0] v);
        int k;
        reg_select = s;
        #200 read_frame_n = 1'b0;
        #50;
        for (k = 0; k < 24; k++) begin
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
            v[23-k] = sdata_in;
        end
        #80 read_frame_n = 1'b1;
        #1000;
    endtask
endmodule

// ===== adc_mode_calibration_control_tb.sv
// Purpose: Self-checking bench for the mode and calibration control.
// Assumes: The front end is replaced by bench-driven measurement pulses.
// Notes: Waits are bounded; a run-out counts as a mismatch.
`timescale 1ns/1ps
module adc_mode_calibration_control_tb import adc_ctrl_pkg::*;;
    logic clock, rst_b, conv_valid, sclk, transmit_frame_n, read_frame_n, reg_select, sdata_in;
    logic sdata_out, sdata_oe_n, result_ready_n, diff_input_first, diff_input_second, high_level_input;
    logic result_width_sel, excitation_current_en, burnout_current_en, unipolar_en, cal_busy;
    logic [WORD_W-1:0] conv_code, w, c, a, b;
    logic [WORD_W-1:0] bg_code [6];
    logic [7:0] pga_gain;
    logic [11:0] filter_code;
    meas_type meas_target;
    int errors, total_checks, i;

    adc_mode_calibration_control adc_mode_calibration_control_inst (.clock, .rst_b, .sclk, .transmit_frame_n,
        .read_frame_n, .reg_select, .sdata_in, .sdata_out, .sdata_oe_n, .result_ready_n, .conv_valid, .conv_code,
        .meas_target, .pga_gain, .diff_input_first, .diff_input_second, .high_level_input, .result_width_sel,
        .excitation_current_en, .burnout_current_en, .unipolar_en, .filter_code, .cal_busy);
    serial_host_model serial_host_model_inst (.sclk, .transmit_frame_n, .read_frame_n, .reg_select, .sdata_in,
        .sdata_out, .sdata_oe_n);

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic wrap_up;
        if (errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic s, input logic [WORD_W-1:0] exp);
        logic [WORD_W-1:0] v;
        serial_host_model_inst.read_word(s, v);
        chk(v, exp);
    endtask

    task automatic wr(input logic s, input logic [WORD_W-1:0] d);
        serial_host_model_inst.write_word(s, d, 24);
    endtask

    function automatic logic [WORD_W-1:0] ctl(input logic [2:0] m, input logic [1:0] ch, input logic [3:0] f);
        ctl = {m, 3'h0, ch, f, 12'h000};
    endfunction

    task automatic chk_set(input logic [WORD_W-1:0] x);
        chk({13'h0, diff_input_first, diff_input_second, high_level_input, pga_gain},
            {13'h0, x[17:16] == 2'h0, x[17:16] == 2'h1, x[17:16] == 2'h2, 8'h01 << x[20:18]});
        chk({8'h0, result_width_sel, excitation_current_en, burnout_current_en, unipolar_en, filter_code},
            {8'h0, x[15:0]});
    endtask

    task automatic conv(input logic [WORD_W-1:0] code);
        @(posedge clock);
        conv_valid <= 1'b1;
        conv_code <= code;
        @(posedge clock);
        conv_valid <= 1'b0;
        repeat (4) @(posedge clock);
    endtask

    task automatic wait_rdy;
        int n;
        for (n = 0; n < 40 && result_ready_n !== 1'b0; n++) @(posedge clock);
        if (result_ready_n !== 1'b0) begin
            chk({23'h0, result_ready_n}, 24'h0);
            wrap_up();
        end
    endtask

    initial begin
        rst_b = 1'b0;
        conv_valid = 1'b0;
        conv_code = 24'h000000;
        errors = 0;
        total_checks = 0;
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        i = $urandom(67);
        repeat (4) @(posedge clock);
        chk_set(CTRL_RST);
        chk({23'h0, result_ready_n}, 24'h1);
        rd(1'b0, CTRL_RST);
        for (i = 0; i < 8; i++) begin
            w = $urandom;
            w[23:21] = MODE_NORMAL;
            w[20:18] = i[2:0];
            w[17:16] = 2'(i % 3);
            wr(1'b0, w);
            chk_set(w);
            rd(1'b0, w);
        end
        serial_host_model_inst.write_word(1'b0, ~w, 23);
        chk_set(w);
        serial_host_model_inst.write_word(1'b0, 24'h16A123, 30);
        chk_set(24'h16A123);
        // Coefficients with short results selected: still full width
        wr(1'b0, ctl(MODE_ZS_ACCESS, CHAN_SECOND, 4'h0));
        a = $urandom;
        wr(1'b1, a);
        rd(1'b1, a);
        serial_host_model_inst.write_word(1'b1, ~a, 20);
        rd(1'b1, a);
        wr(1'b0, ctl(MODE_FS_ACCESS, CHAN_SECOND, 4'h0));
        b = $urandom;
        wr(1'b1, b);
        rd(1'b1, b);
        wr(1'b0, ctl(MODE_FS_ACCESS, CHAN_FIRST, 4'h0));
        rd(1'b1, COEF_FS_RST);
        wr(1'b0, ctl(MODE_NORMAL, CHAN_FIRST, 4'h8));
        c = $urandom;
        conv(c);
        wait_rdy();
        rd(1'b1, c);
        repeat (10) @(posedge clock);
        chk({23'h0, result_ready_n}, 24'h1);
        wr(1'b0, ctl(MODE_NORMAL, CHAN_FIRST, 4'h0));
        c = $urandom;
        conv(c);
        wait_rdy();
        w = c & SHORT_RESULT_MASK;
        rd(1'b1, w);
        // Full-scale step on the second input
        wr(1'b0, ctl(MODE_SYS_FULL, CHAN_SECOND, 4'h0));
        chk({21'h0, meas_target, cal_busy}, {21'h0, MEAS_INPUT, 1'b1});
        c = $urandom;
        conv(c);
        wait_rdy();
        chk({23'h0, cal_busy}, 24'h0);
        rd(1'b0, ctl(MODE_NORMAL, CHAN_SECOND, 4'h0));
        wr(1'b0, ctl(MODE_FS_ACCESS, CHAN_SECOND, 4'h0));
        rd(1'b1, c);
        // Offset calibration on the high-level input
        wr(1'b0, ctl(MODE_SYS_OFFSET, CHAN_HIGH, 4'h0));
        chk({22'h0, meas_target}, {22'h0, MEAS_INPUT});
        a = $urandom;
        conv(a);
        chk({22'h0, meas_target}, {22'h0, MEAS_REF});
        b = $urandom;
        conv(b);
        wait_rdy();
        rd(1'b0, ctl(MODE_NORMAL, CHAN_HIGH, 4'h0));
        rd(1'b1, w);
        wr(1'b0, ctl(MODE_FS_ACCESS, CHAN_HIGH, 4'h0));
        rd(1'b1, b);
        wr(1'b0, ctl(MODE_ZS_ACCESS, CHAN_HIGH, 4'h0));
        rd(1'b1, a);
        // Background: six slots per published result
        wr(1'b0, ctl(MODE_BACKGROUND, CHAN_FIRST, 4'h8));
        chk({23'h0, result_ready_n}, 24'h1);
        for (i = 0; i < 6; i++) begin
            chk({22'h0, meas_target}, 24'(i % 3));
            bg_code[i] = $urandom;
            conv(bg_code[i]);
            if (i == 0) begin
                chk({23'h0, result_ready_n}, 24'h0);
            end
        end
        wr(1'b0, ctl(MODE_ZS_ACCESS, CHAN_FIRST, 4'h0));
        rd(1'b1, bg_code[4]);
        wr(1'b0, ctl(MODE_FS_ACCESS, CHAN_FIRST, 4'h0));
        rd(1'b1, bg_code[5]);
        wrap_up();
    end
endmodule

bind adc_mode_calibration_control adc_mode_calibration_control_checker chk_inst (.clock, .rst_b, .transmit_frame_n,
    .read_frame_n, .sdata_oe_n, .result_ready_n, .conv_valid, .meas_target, .pga_gain, .diff_input_first,
    .diff_input_second, .high_level_input, .result_width_sel, .excitation_current_en, .burnout_current_en,
    .unipolar_en, .filter_code, .cal_busy);
